// ===== rtl/pse_engine.sv
// Sequencing engine: state program, actions, run control, link end
// Notes on behaviour
// - initial state runs roll call above 16 rails, CRC, ID, ready
// - any initial failure halts until reset command
// - initial success moves to state one
// - entry list runs once before loop list
// - loop repeats until go-to transfers state
// - input change restarts loop list at top
// - set actions drive pins, variables, timers
// - monitor compares source against threshold
// - monitors combine logically to declare fault
// - record action captures all pin status
// - peer bus at most one megahertz, sixteen
// - one master broadcasts next state to slaves
// - up to 1023 user states supported
// - all devices step states in sync
// - debug breakpoint pauses until start command
// - breakpoints ignored outside debug mode
// - run command starts, stops, resets to zero
// - engine runs after power-up without command
// - host sends run command to every device
// - four eight-bit variables set and monitored
// - variable command reads variables back
// - host variable writes steer monitor outcomes
// - latest of engine or host drives pins 0 to 15; host cannot drive pins 16 to 24
`timescale 1ns/10ps
`include "pse_defs.svh"
module pse_engine
	import pse_pkg::*;
#(
	parameter int NUM_STATES = 1024,
	parameter int PC_W = 8,
	parameter int PEER_WAIT = 100000
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	pse_link_if.dev link,
	input wire logic cfg_we_i,
	input wire logic cfg_sel_i,
	input wire logic [9:0] cfg_addr_i,
	input wire logic [31:0] cfg_data_i,
	input wire logic cfg_done_i,
	input wire logic [8:0] rail_count_i,
	input wire logic roll_call_ok_i,
	input wire logic crc_ok_i,
	input wire logic id_aligned_i,
	input wire logic peers_ready_i,
	input wire logic debug_mode_i,
	input wire logic [16:0] sense_ok_i,
	input wire logic [24:0] pins_i,
	output logic [24:0] pins_o,
	output logic [24:0] pins_oe_o,
	output logic [9:0] state_o,
	output logic running_o,
	output logic halted_o,
	output logic paused_o,
	output logic fault_o,
	output logic rec_valid_o,
	output logic [41:0] rec_data_o
);
	localparam int TICK_CYC = `PSE_TICK_NS / `PSE_CLK_NS;
	pse_action_t prog [2**PC_W];
	logic [PC_W-1:0] st_entry [NUM_STATES];
	logic [PC_W-1:0] st_loop [NUM_STATES];
	logic st_bp [NUM_STATES];
	pse_eng_t eng_reg;
	logic [9:0] cur_reg;
	logic [PC_W-1:0] pc_reg;
	logic acc_reg, run_reg, fault_reg;
	logic [16:0] init_cnt_reg;
	logic [7:0] var_reg [4];
	logic [15:0] tmr_reg [2];
	logic [1:0] tmr_on_reg;
	logic [7:0] tick_reg;
	logic [16:0] sense_s1, sense_s2, sense_prev;
	logic [24:0] pins_s1, pins_s2, pins_prev;
	logic cmd_tog, ack_tog, tog_s1, tog_s2, tog_s3;
	logic ack_s1, ack_s2, rsp_tog, rsp_s1, rsp_s2, rsp_s3;
	logic rdy_s1, rdy_s2;
	logic [7:0] hold_code, rsp_hold;
	logic hold_write;
	logic [15:0] hold_data;
	logic evt, run_cmd, var_wr, var_rd, pin_wr, bcast, exec, cond, taken;
	logic change, go_en, init_ok;
	logic [9:0] go_state;
	pse_action_t act;

	// ==========================================================
	// Link domain: command capture and response
	// ==========================================================
	assign link.cmd_ready = (cmd_tog == ack_s2);
	assign link.peer_ready = rdy_s2;
	always_ff @(posedge link.link_clk or negedge rst_n_i)
		if (!rst_n_i)
		begin
			cmd_tog <= 1'b0;
			hold_code <= 8'h00;
			hold_write <= 1'b0;
			hold_data <= 16'h0000;
		end
		else if (link.cmd_valid && link.cmd_ready)
		begin
			cmd_tog <= ~cmd_tog;
			hold_code <= link.cmd_code;
			hold_write <= link.cmd_write;
			hold_data <= link.cmd_data;
		end
	always_ff @(posedge link.link_clk or negedge rst_n_i)
		if (!rst_n_i)
		begin
			{ack_s1, ack_s2, rsp_s1, rsp_s2, rsp_s3} <= 5'h00;
			{rdy_s1, rdy_s2} <= 2'h0;
			link.rsp_valid <= 1'b0;
			link.rsp_data <= 8'h00;
		end
		else
		begin
			ack_s1 <= ack_tog;
			ack_s2 <= ack_s1;
			rsp_s1 <= rsp_tog;
			rsp_s2 <= rsp_s1;
			rsp_s3 <= rsp_s2;
			rdy_s1 <= (eng_reg == PSE_ENG_LOOP);
			rdy_s2 <= rdy_s1;
			link.rsp_valid <= rsp_s2 ^ rsp_s3;
			if (rsp_s2 ^ rsp_s3)
				link.rsp_data <= rsp_hold;
		end

	// ==========================================================
	// Core domain: crossings and command decode
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			{tog_s1, tog_s2, tog_s3, ack_tog} <= 4'h0;
			{sense_s1, sense_s2, sense_prev} <= '0;
			{pins_s1, pins_s2, pins_prev} <= '0;
		end
		else if (en_i)
		begin
			tog_s1 <= cmd_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			if (evt)
				ack_tog <= ~ack_tog;
			sense_s1 <= sense_ok_i;
			sense_s2 <= sense_s1;
			sense_prev <= sense_s2;
			pins_s1 <= pins_i;
			pins_s2 <= pins_s1;
			pins_prev <= pins_s2;
		end
	assign evt = tog_s2 ^ tog_s3;
	assign run_cmd = evt && hold_write && hold_code == `PSE_CMD_RUN;
	assign var_wr = evt && hold_write && hold_code == `PSE_CMD_VAR;
	assign var_rd = evt && !hold_write && hold_code == `PSE_CMD_VAR;
	assign pin_wr = evt && hold_write && hold_code == `PSE_CMD_PINS;
	assign bcast = evt && hold_write && hold_code == `PSE_CMD_BCAST;
	assign change = (sense_s2 != sense_prev) || (pins_s2 != pins_prev);
	assign init_ok = !(rail_count_i > `PSE_RAIL_SPLIT && !roll_call_ok_i) &&
		crc_ok_i && id_aligned_i;

	// ==========================================================
	// Configuration download
	// ==========================================================
	always_ff @(posedge clk_i)
		if (en_i && cfg_we_i)
		begin
			if (!cfg_sel_i)
				prog[cfg_addr_i[PC_W-1:0]] <= cfg_data_i;
			else
			begin
				st_bp[cfg_addr_i] <= cfg_data_i[16];
				st_entry[cfg_addr_i] <= cfg_data_i[8+:PC_W];
				st_loop[cfg_addr_i] <= cfg_data_i[PC_W-1:0];
			end
		end

	// ==========================================================
	// Action evaluation
	// ==========================================================
	assign act = prog[pc_reg];
	assign exec = run_reg && (eng_reg == PSE_ENG_ENTRY ||
		eng_reg == PSE_ENG_LOOP);
	always_comb
	begin
		case (act.src)
			2'h0: cond = (act.idx < 7'd17) &&
				(sense_s2[act.idx[4:0]] == act.arg[0]);
			2'h1: cond = (act.idx < 7'd25) &&
				(pins_s2[act.idx[4:0]] == act.arg[0]);
			2'h2: cond = var_reg[act.idx[1:0]] >= act.arg[7:0];
			default: cond = tmr_reg[act.idx[0]] >= act.arg;
		endcase
		case (act.mode)
			2'h1: taken = acc_reg;
			2'h2: taken = !acc_reg;
			default: taken = 1'b1;
		endcase
		go_en = 1'b0;
		go_state = act.arg[9:0];
		if (eng_reg == PSE_ENG_INIT && cfg_done_i && init_ok &&
			peers_ready_i)
		begin
			go_en = 1'b1;
			go_state = `PSE_STATE_FIRST;
		end
		else if (bcast && eng_reg != PSE_ENG_INIT &&
			eng_reg != PSE_ENG_HALT)
		begin
			go_en = 1'b1;
			go_state = hold_data[9:0];
		end
		else if (exec && !change && act.op == PSE_OP_GOTO && taken)
			go_en = 1'b1;
	end

	// ==========================================================
	// Engine sequencing
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			eng_reg <= PSE_ENG_INIT;
			cur_reg <= `PSE_STATE_INIT;
			pc_reg <= '0;
			acc_reg <= 1'b0;
			run_reg <= 1'b1;
			fault_reg <= 1'b0;
			init_cnt_reg <= '0;
		end
		else if (en_i)
		begin
			if (run_cmd && hold_data[`PSE_RUN_STOP])
				run_reg <= 1'b0;
			else if (run_cmd && hold_data[`PSE_RUN_START])
				run_reg <= 1'b1;
			if (run_cmd && hold_data[`PSE_RUN_RESET])
			begin
				eng_reg <= PSE_ENG_INIT;
				cur_reg <= `PSE_STATE_INIT;
				run_reg <= 1'b1;
				fault_reg <= 1'b0;
				init_cnt_reg <= '0;
			end
			else if (go_en && (run_reg || bcast))
			begin
				cur_reg <= go_state;
				acc_reg <= 1'b0;
				if (exec && !bcast && act.op == PSE_OP_GOTO && act.fault)
					fault_reg <= 1'b1;
				pc_reg <= st_entry[go_state];
				eng_reg <= (debug_mode_i && st_bp[go_state]) ?
					PSE_ENG_BREAK : PSE_ENG_ENTRY;
			end
			else if (run_reg)
				case (eng_reg)
					PSE_ENG_INIT:
						if (cfg_done_i)
						begin
							init_cnt_reg <= init_cnt_reg + 17'd1;
							if (!init_ok ||
								init_cnt_reg == 17'(PEER_WAIT - 1))
								eng_reg <= PSE_ENG_HALT;
						end
					PSE_ENG_BREAK:
						if (run_cmd && hold_data[`PSE_RUN_START])
							eng_reg <= PSE_ENG_ENTRY;
					PSE_ENG_ENTRY:
						if (act.op == PSE_OP_END)
						begin
							eng_reg <= PSE_ENG_LOOP;
							pc_reg <= st_loop[cur_reg];
						end
						else
							pc_reg <= pc_reg + 1'b1;
					PSE_ENG_LOOP:
						if (change || act.op == PSE_OP_END)
							pc_reg <= st_loop[cur_reg];
						else
							pc_reg <= pc_reg + 1'b1;
					default: ;
				endcase
			if (exec && !go_en && act.op == PSE_OP_MON)
				case (act.mode)
					2'h1: acc_reg <= acc_reg & cond;
					2'h2: acc_reg <= acc_reg | cond;
					default: acc_reg <= cond;
				endcase
		end

	// ==========================================================
	// Variables, timers, pins, records
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			for (int i = 0; i < 4; i++)
				var_reg[i] <= 8'h00;
			rsp_tog <= 1'b0;
			rsp_hold <= 8'h00;
		end
		else if (en_i)
		begin
			if (exec && act.op == PSE_OP_SET_VAR)
				var_reg[act.idx[1:0]] <= act.arg[7:0];
			if (var_wr)
				var_reg[hold_data[`PSE_VAR_IDX_HI:`PSE_VAR_IDX_LO]] <=
					hold_data[7:0];
			if (var_rd)
			begin
				rsp_hold <=
					var_reg[hold_data[`PSE_VAR_IDX_HI:`PSE_VAR_IDX_LO]];
				rsp_tog <= ~rsp_tog;
			end
		end
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			tick_reg <= 8'h00;
			tmr_on_reg <= 2'h0;
			tmr_reg[0] <= 16'h0000;
			tmr_reg[1] <= 16'h0000;
		end
		else if (en_i)
		begin
			tick_reg <= (tick_reg == 8'(TICK_CYC - 1)) ? 8'h00 :
				tick_reg + 8'h01;
			for (int i = 0; i < 2; i++)
				if (tick_reg == 8'h00 && tmr_on_reg[i] &&
					tmr_reg[i] != 16'hffff)
					tmr_reg[i] <= tmr_reg[i] + 16'h0001;
			if (exec && act.op == PSE_OP_SET_TMR)
			begin
				tmr_reg[act.idx[0]] <= 16'h0000;
				tmr_on_reg[act.idx[0]] <= (act.mode == 2'h0);
			end
		end
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			pins_o <= '0;
			pins_oe_o <= '0;
			rec_valid_o <= 1'b0;
			rec_data_o <= '0;
		end
		else if (en_i)
		begin
			// set action drives pin, latest wins
			if (exec && act.op == PSE_OP_SET_PIN && act.idx < 7'd25)
			begin
				pins_o[act.idx[4:0]] <= act.arg[0];
				pins_oe_o[act.idx[4:0]] <= 1'b1;
			end
			if (pin_wr)
			begin
				pins_o[15:0] <= hold_data;
				pins_oe_o[15:0] <= 16'hffff;
			end
			rec_valid_o <= exec && !change && act.op == PSE_OP_RECORD;
			if (exec && !change && act.op == PSE_OP_RECORD)
				rec_data_o <= {sense_s2, pins_s2};
		end

	assign state_o = cur_reg;
	assign running_o = run_reg;
	assign halted_o = (eng_reg == PSE_ENG_HALT);
	assign paused_o = (eng_reg == PSE_ENG_BREAK);
	assign fault_o = fault_reg;
endmodule : pse_engine

// ===== pkg/pse_defs.svh
// Constants shared by both ends of the power sequencing engine link
`ifndef PSE_DEFS_SVH
`define PSE_DEFS_SVH
`define PSE_CMD_RUN 8'hd8
`define PSE_CMD_VAR 8'hf7
`define PSE_CMD_PINS 8'hf0
`define PSE_CMD_BCAST 8'hfe
`define PSE_RUN_START 0
`define PSE_RUN_STOP 1
`define PSE_RUN_RESET 2
`define PSE_VAR_IDX_HI 9
`define PSE_VAR_IDX_LO 8
`define PSE_RAIL_SPLIT 9'h010
`define PSE_MAX_PEERS 16
`define PSE_STATE_INIT 10'h000
`define PSE_STATE_FIRST 10'h001
`define PSE_CLK_HZ 200000000
`define PSE_LINK_MAX_HZ 1000000
`define PSE_CLK_NS 5
`define PSE_TICK_NS 1000
`define PSE_NUM_PINS 25
`define PSE_NUM_SENSE 17
`endif

// ===== pkg/pse_pkg.sv
// Types of the power sequencing engine
package pse_pkg;
	typedef enum logic [3:0] {
		PSE_OP_END = 4'h0,
		PSE_OP_SET_PIN = 4'h1,
		PSE_OP_SET_VAR = 4'h2,
		PSE_OP_SET_TMR = 4'h3,
		PSE_OP_MON = 4'h4,
		PSE_OP_GOTO = 4'h5,
		PSE_OP_RECORD = 4'h6
	} pse_op_t;
	typedef struct packed {
		logic [3:0] op;
		logic [1:0] mode;
		logic fault;
		logic [1:0] src;
		logic [6:0] idx;
		logic [15:0] arg;
	} pse_action_t;
	typedef enum logic [2:0] {
		PSE_ENG_INIT = 3'b000,
		PSE_ENG_HALT = 3'b001,
		PSE_ENG_BREAK = 3'b010,
		PSE_ENG_ENTRY = 3'b011,
		PSE_ENG_LOOP = 3'b100
	} pse_eng_t;
	typedef enum logic [1:0] {
		PSE_HOST_IDLE = 2'b00,
		PSE_HOST_SEND = 2'b01,
		PSE_HOST_WAIT = 2'b10
	} pse_host_t;
endpackage : pse_pkg

// ===== pkg/pse_link_if.sv
// Link between the management host and a sequencing engine
`timescale 1ns/10ps
interface pse_link_if;
	logic link_clk;
	logic cmd_valid;
	logic cmd_write;
	logic [7:0] cmd_code;
	logic [15:0] cmd_data;
	logic cmd_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic peer_ready;
	modport dev (input link_clk, cmd_valid, cmd_write, cmd_code, cmd_data,
		output cmd_ready, rsp_valid, rsp_data, peer_ready);
	modport host (output link_clk, cmd_valid, cmd_write, cmd_code, cmd_data,
		input cmd_ready, rsp_valid, rsp_data, peer_ready);
endinterface : pse_link_if

// ===== rtl/pse_host.sv
// Management host end: link clock divider, command issue, replies
`timescale 1ns/10ps
`include "pse_defs.svh"
module pse_host
	import pse_pkg::*;
#(
	parameter int LINK_DIV = `PSE_CLK_HZ / `PSE_LINK_MAX_HZ
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	pse_link_if.host link,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [7:0] req_code_i,
	input wire logic [15:0] req_data_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_data_o,
	output logic peer_ready_o
);
	localparam int HALF = LINK_DIV / 2;
	pse_host_t st_reg;
	logic [15:0] div_reg;
	logic lclk_reg, tick, fall;
	logic cv_reg, cw_reg;
	logic [7:0] cc_reg;
	logic [15:0] cd_reg;
	logic rv_s1, rv_s2, rv_s3, rdy_s1, rdy_s2, pr_s1;
	logic [7:0] rd_s1, rd_s2;

	// ==========================================================
	// Link clock divider
	// ==========================================================
	// link rate at most one megahertz
	assign tick = (div_reg == 16'(HALF - 1));
	assign fall = tick && lclk_reg;
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			div_reg <= 16'h0000;
			lclk_reg <= 1'b0;
		end
		else if (en_i)
		begin
			div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
			if (tick)
				lclk_reg <= ~lclk_reg;
		end
	assign link.link_clk = lclk_reg;
	assign link.cmd_valid = cv_reg;
	assign link.cmd_write = cw_reg;
	assign link.cmd_code = cc_reg;
	assign link.cmd_data = cd_reg;

	// ==========================================================
	// Synchronisers for link-side outputs
	// ==========================================================
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			{rv_s1, rv_s2, rv_s3, rdy_s1, rdy_s2} <= 5'h00;
			{pr_s1, peer_ready_o} <= 2'h0;
			{rd_s1, rd_s2} <= 16'h0000;
		end
		else if (en_i)
		begin
			rv_s1 <= link.rsp_valid;
			rv_s2 <= rv_s1;
			rv_s3 <= rv_s2;
			rd_s1 <= link.rsp_data;
			rd_s2 <= rd_s1;
			rdy_s1 <= link.cmd_ready;
			rdy_s2 <= rdy_s1;
			pr_s1 <= link.peer_ready;
			peer_ready_o <= pr_s1;
		end

	// ==========================================================
	// Command issue and reply capture
	// ==========================================================
	assign req_ready_o = (st_reg == PSE_HOST_IDLE) && rdy_s2;
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			st_reg <= PSE_HOST_IDLE;
			cv_reg <= 1'b0;
			cw_reg <= 1'b0;
			cc_reg <= 8'h00;
			cd_reg <= 16'h0000;
			rsp_valid_o <= 1'b0;
			rsp_data_o <= 8'h00;
		end
		else if (en_i)
		begin
			rsp_valid_o <= 1'b0;
			case (st_reg)
				PSE_HOST_IDLE:
					if (req_valid_i && req_ready_o)
					begin
						cw_reg <= req_write_i;
						cc_reg <= req_code_i;
						cd_reg <= req_data_i;
						st_reg <= PSE_HOST_SEND;
					end
				PSE_HOST_SEND:
					if (fall)
					begin
						cv_reg <= ~cv_reg;
						if (cv_reg)
							st_reg <= cw_reg ? PSE_HOST_IDLE :
								PSE_HOST_WAIT;
					end
				PSE_HOST_WAIT:
					// variable value returned
					// Trailing edge of valid: reply data long settled
					if (rv_s3 && !rv_s2)
					begin
						rsp_valid_o <= 1'b1;
						rsp_data_o <= rd_s2;
						st_reg <= PSE_HOST_IDLE;
					end
				default: st_reg <= PSE_HOST_IDLE;
			endcase
		end
endmodule : pse_host

// ===== tb/pse_link_checker.sv
// Protocol checker for the host to engine link
`timescale 1ns/10ps
`include "pse_defs.svh"
module pse_link_checker (
	input wire logic link_clk,
	input wire logic rst_n_i,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_ready,
	input wire logic rsp_valid
);
	logic rd_take, wr_take, rd_pend_reg;
	assign rd_take = cmd_valid && cmd_ready && !cmd_write &&
		cmd_code == `PSE_CMD_VAR;
	assign wr_take = cmd_valid && cmd_ready && cmd_write;
	// Read outstanding on the link
	always_ff @(posedge link_clk or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rd_pend_reg <= 1'b0;
		else if (rd_take)
			rd_pend_reg <= 1'b1;
		else if (rsp_valid)
			rd_pend_reg <= 1'b0;
	end
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!rst_n_i);
	// ============================================================
	// Link properties
	property p_valid_once;
		cmd_valid |=> !cmd_valid;
	endproperty
	a_valid_once: assert property (p_valid_once)
		else $error("command valid held past one link period");
	property p_valid_ready;
		cmd_valid |-> cmd_ready;
	endproperty
	a_valid_ready: assert property (p_valid_ready)
		else $error("command sent while device not ready");
	property p_take_busy;
		cmd_valid && cmd_ready |=> !cmd_ready;
	endproperty
	a_take_busy: assert property (p_take_busy)
		else $error("device still ready after taking a command");
	property p_ready_back;
		$fell(cmd_ready) |-> ##[1:6] cmd_ready;
	endproperty
	a_ready_back: assert property (p_ready_back)
		else $error("device busy too long");
	property p_rsp_once;
		rsp_valid |=> !rsp_valid;
	endproperty
	a_rsp_once: assert property (p_rsp_once)
		else $error("reply valid longer than one link period");
	property p_read_rsp;
		rd_take |-> ##[1:8] rsp_valid;
	endproperty
	a_read_rsp: assert property (p_read_rsp)
		else $error("variable read got no reply");
	property p_write_quiet;
		wr_take |=> !rsp_valid [*4];
	endproperty
	a_write_quiet: assert property (p_write_quiet)
		else $error("write produced a reply");
	property p_rsp_cause;
		rsp_valid |-> rd_pend_reg;
	endproperty
	a_rsp_cause: assert property (p_rsp_cause)
		else $error("reply without a pending read");
endmodule : pse_link_checker

// ===== tb/tb_top.sv
// Self-checking bench for the host and engine pair
`timescale 1ns/10ps
`include "pse_defs.svh"
module tb_top import pse_pkg::*;;
	logic clk_i, rst_n_i, en_i, req_valid_i, req_write_i, req_ready_o;
	logic rsp_valid_o, peer_ready_o, cfg_we_i, cfg_sel_i, cfg_done_i;
	logic [7:0] req_code_i, rsp_data_o, rd, v;
	logic [15:0] req_data_i;
	logic [9:0] cfg_addr_i, state_o;
	logic [31:0] cfg_data_i;
	logic [8:0] rail_count_i;
	logic roll_call_ok_i, crc_ok_i, id_aligned_i, peers_ready_i, debug_mode_i;
	logic [16:0] sense_ok_i;
	logic [24:0] pins_i, pins_o, pins_oe_o;
	logic running_o, halted_o, paused_o, fault_o, rec_valid_o;
	logic [41:0] rec_data_o, snap;
	logic [31:0] prog [15];
	logic [12:0] init_case [5];
	int err_total, check_count;
	pse_link_if i_pse_link_if();
	pse_host #(.LINK_DIV(8)) i_pse_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.en_i(en_i), .link(i_pse_link_if), .req_valid_i(req_valid_i),
		.req_write_i(req_write_i), .req_code_i(req_code_i),
		.req_data_i(req_data_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
		.peer_ready_o(peer_ready_o));
	pse_engine #(.PEER_WAIT(20)) i_pse_engine (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .en_i(en_i), .link(i_pse_link_if),
		.cfg_we_i(cfg_we_i), .cfg_sel_i(cfg_sel_i), .cfg_addr_i(cfg_addr_i),
		.cfg_data_i(cfg_data_i), .cfg_done_i(cfg_done_i),
		.rail_count_i(rail_count_i), .roll_call_ok_i(roll_call_ok_i),
		.crc_ok_i(crc_ok_i), .id_aligned_i(id_aligned_i),
		.peers_ready_i(peers_ready_i), .debug_mode_i(debug_mode_i),
		.sense_ok_i(sense_ok_i), .pins_i(pins_i), .pins_o(pins_o),
		.pins_oe_o(pins_oe_o), .state_o(state_o), .running_o(running_o),
		.halted_o(halted_o), .paused_o(paused_o), .fault_o(fault_o),
		.rec_valid_o(rec_valid_o), .rec_data_o(rec_data_o));
	pse_link_checker i_pse_link_checker (.link_clk(i_pse_link_if.link_clk),
		.rst_n_i(rst_n_i), .cmd_valid(i_pse_link_if.cmd_valid),
		.cmd_write(i_pse_link_if.cmd_write), .cmd_code(i_pse_link_if.cmd_code),
		.cmd_ready(i_pse_link_if.cmd_ready),
		.rsp_valid(i_pse_link_if.rsp_valid));
	// ============================================================
	// Helpers
	function automatic logic [31:0] act(input pse_op_t op, input int md, f,
		src, idx, arg);
		return {op, md[1:0], f[0], src[1:0], idx[6:0], arg[15:0]};
	endfunction : act
	function automatic logic met(input int w, input logic [9:0] s);
		case (w)
			0: return state_o === s;
			1: return halted_o === s[0];
			2: return paused_o === s[0];
			3: return rec_valid_o === 1'b1;
			4: return pins_o[0] === s[0];
			5: return running_o === s[0];
			default: return fault_o === s[0];
		endcase
	endfunction : met
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [41:0] e, g);
		check_count++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", name, e, g);
			err_total++;
		end
	endtask : chk
	task automatic wait_on(input string name, input int w, input logic [9:0] s);
		int n = 0;
		check_count++;
		while (!met(w, s) && n < 5000)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 5000)
		begin
			$display("BAD %s expected %h seen timeout", name, s);
			err_total++;
			summarize();
		end
	endtask : wait_on
	task automatic host_req(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		int n = 0;
		@(negedge clk_i);
		req_valid_i = 1'b1;
		req_write_i = w;
		req_code_i = c;
		req_data_i = d;
		while (req_ready_o !== 1'b1 && n < 5000)
		begin
			@(negedge clk_i);
			n++;
		end
		@(negedge clk_i);
		req_valid_i = 1'b0;
		while (!w && rsp_valid_o !== 1'b1 && n < 5000)
		begin
			@(negedge clk_i);
			n++;
		end
		rd = rsp_data_o;
		if (n >= 5000)
		begin
			$display("BAD host expected reply seen timeout");
			err_total++;
			summarize();
		end
	endtask : host_req
	task automatic cfg(input logic s, input int a, input logic [31:0] d);
		@(negedge clk_i);
		cfg_we_i = 1'b1;
		cfg_sel_i = s;
		cfg_addr_i = a[9:0];
		cfg_data_i = d;
		@(negedge clk_i);
		cfg_we_i = 1'b0;
	endtask : cfg
	// ============================================================
	// Clock and watchdog
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (100000) @(posedge clk_i);
		$display("BAD run expected done seen timeout");
		err_total++;
		summarize();
	end
	// ============================================================
	// Main sequence
	initial
	begin
		{err_total, check_count} = '0;
		void'($urandom(32'hb3cb));
		{rst_n_i, en_i, req_valid_i, req_write_i, cfg_we_i, cfg_sel_i} = 6'h10;
		{req_code_i, req_data_i, cfg_addr_i, cfg_data_i} = '0;
		{cfg_done_i, debug_mode_i, pins_i} = '0;
		{rail_count_i, roll_call_ok_i, crc_ok_i, id_aligned_i} = 12'h00f;
		{peers_ready_i, sense_ok_i} = '1;
		prog = '{act(PSE_OP_SET_PIN, 0, 0, 0, 0, 1),
			act(PSE_OP_SET_VAR, 0, 0, 0, 0, 5), act(PSE_OP_END, 0, 0, 0, 0, 0),
			act(PSE_OP_MON, 0, 0, 2, 0, 16), act(PSE_OP_GOTO, 1, 0, 0, 0, 2),
			act(PSE_OP_END, 0, 0, 0, 0, 0), act(PSE_OP_SET_PIN, 0, 0, 0, 1, 1),
			act(PSE_OP_RECORD, 0, 0, 0, 0, 0), act(PSE_OP_END, 0, 0, 0, 0, 0),
			act(PSE_OP_MON, 0, 0, 0, 0, 0), act(PSE_OP_MON, 1, 0, 1, 24, 1),
			act(PSE_OP_GOTO, 1, 1, 0, 0, 3), act(PSE_OP_END, 0, 0, 0, 0, 0),
			act(PSE_OP_END, 0, 0, 0, 0, 0), act(PSE_OP_END, 0, 0, 0, 0, 0)};
		init_case = '{{9'h011, 4'h7}, {9'h001, 4'hb}, {9'h001, 4'hd},
			{9'h001, 4'he}, {9'h010, 4'h7}};
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		chk("reset_state", 42'h0, 42'(state_o));
		chk("reset_run", 42'h1, 42'(running_o));
		for (int i = 0; i < 15; i++)
			cfg(1'b0, i, prog[i]);
		cfg(1'b1, 1, 32'h0001_0003);
		cfg(1'b1, 2, 32'h0000_0609);
		cfg(1'b1, 3, 32'h0000_0d0e);
		for (int i = 0; i < 5; i++)
		begin
			{rail_count_i, roll_call_ok_i, crc_ok_i, id_aligned_i,
				peers_ready_i} = init_case[i];
			cfg_done_i = 1'b1;
			if (i > 0)
			begin
				host_req(1'b1, `PSE_CMD_RUN, 16'h0004);
				wait_on("halt_clear", 1, 10'h000);
			end
			if (i < 4)
			begin
				wait_on("halt", 1, 10'h001);
				chk("halt_state", 42'h0, 42'(state_o));
			end
			else
				wait_on("state_one", 0, 10'h001);
		end
		wait_on("entry_pin", 4, 10'h001);
		host_req(1'b0, `PSE_CMD_VAR, 16'h0000);
		chk("var_zero", 42'h5, 42'(rd));
		for (int i = 1; i < 4; i++)
		begin
			v = 8'($urandom);
			host_req(1'b1, `PSE_CMD_VAR, {6'h00, i[1:0], v});
			host_req(1'b0, `PSE_CMD_VAR, {6'h00, i[1:0], 8'h00});
			chk("var_back", 42'(v), 42'(rd));
		end
		chk("peer_ready", 42'h1, 42'(peer_ready_o));
		snap = {17'($urandom) | 17'h00001, 25'($urandom) & 25'h0ffffff};
		{sense_ok_i, pins_i} = snap;
		host_req(1'b1, `PSE_CMD_VAR, 16'h0010);
		wait_on("record", 3, 10'h000);
		chk("snapshot", snap, rec_data_o);
		chk("state_two", 42'h2, 42'(state_o));
		sense_ok_i[0] = 1'b0;
		pins_i[24] = 1'b1;
		wait_on("state_three", 0, 10'h003);
		wait_on("fault", 6, 10'h001);
		host_req(1'b1, `PSE_CMD_PINS, 16'h0000);
		wait_on("host_pin", 4, 10'h000);
		chk("pin_oe", 42'h000ffff, 42'(pins_oe_o));
		host_req(1'b1, `PSE_CMD_RUN, 16'h0002);
		wait_on("stopped", 5, 10'h000);
		host_req(1'b1, `PSE_CMD_RUN, 16'h0001);
		wait_on("started", 5, 10'h001);
		debug_mode_i = 1'b1;
		host_req(1'b1, `PSE_CMD_RUN, 16'h0004);
		wait_on("restate", 0, 10'h001);
		wait_on("paused", 2, 10'h001);
		chk("held_pin", 42'h0, 42'(pins_o[0]));
		chk("fault_clr", 42'h0, 42'(fault_o));
		host_req(1'b1, `PSE_CMD_RUN, 16'h0001);
		wait_on("resumed", 2, 10'h000);
		wait_on("engine_pin", 4, 10'h001);
		host_req(1'b1, `PSE_CMD_BCAST, 16'h0003);
		wait_on("bcast_state", 0, 10'h003);
		chk("bcast_fault", 42'h0, 42'(fault_o));
		summarize();
	end
endmodule : tb_top
